/* hdl/switch_route_select.sv */
// Serial register slave and crossbar select decode for a 4-source link switch
//
// Contract
// - Fast enable low puts fast path standby
// - Fast mode 00 quad, 01 dual, 10 single
// - Fast mode 11 ignored, old mode kept
// - Quad: low two pick bits choose source
// - Dual: three bits choose pair, lower first
// - Single: four bits choose one channel
// - Side enable low disconnects common lines
// - Side mode 00 quad, 01 dual, 10 single
// - Side mode 11 ignored, old mode kept
// - Side quad: low bits choose source
// - Side dual: A/B low, C/D high
// - Side single: four bits choose one line
// - Fast register layout, offset 00, reset 40
// - Side register layout, offset 01, reset 40
`timescale 1ns/1ps
`include "switch_route_select_defines.svh"
module switch_route_select #(
  parameter logic [6:0] DEV_ADDR = 7'h48 // Arbitrary bus address
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Serial register bus, open drain data
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_drive_b,
  // Crossbar controls
  output switch_route_select_pkg::route_t fast_route_q,
  output switch_route_select_pkg::route_t side_common_lines_q
);
  // Refuse an address that every slave would answer
  if (DEV_ADDR == 7'h00) begin
    $error("General call address cannot be the device address");
  end

  function automatic switch_route_select_pkg::route_t route_of(input logic [7:0] r,
                                                               input logic side);
    switch_route_select_pkg::route_t o;
    logic [1:0] kk;
    o.on = r[`ROUTE_EN_BIT];
    o.pick = '0;
    for (int k = 0; k < 4; k++) begin
      kk = 2'(k);
      unique case (r[`ROUTE_MODE_HI:`ROUTE_MODE_LO])
        `MODE_QUAD: o.pick[k] = {r[1:0], kk};
        `MODE_DUAL: begin
          if (side) begin
            o.pick[k] = {kk[1], r[2], r[1:0]};
          end else begin
            o.pick[k] = {r[2:1], r[0], kk[1]};
          end
        end
        `MODE_SINGLE: o.pick[k] = r[`ROUTE_PICK_HI:0];
        default: o.pick[k] = {r[1:0], kk};
      endcase
    end
    return o;
  endfunction

  // Mode field update that refuses the illegal code
  function automatic logic [7:0] reg_write(input logic [7:0] old, input logic [7:0] wd);
    logic [7:0] n;
    n = {1'b0, wd[6:0]};
    if (wd[`ROUTE_MODE_HI:`ROUTE_MODE_LO] == `MODE_ILLEGAL) begin
      n[`ROUTE_MODE_HI:`ROUTE_MODE_LO] = old[`ROUTE_MODE_HI:`ROUTE_MODE_LO];
    end
    return n;
  endfunction

  // Pin synchronisers; stage 1 feeds only stage 2
  logic [2:0] scl_s_q;
  logic [2:0] sda_s_q;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      scl_s_q <= 3'h7;
      sda_s_q <= 3'h7;
    end else begin
      scl_s_q <= {scl_s_q[1:0], scl};
      sda_s_q <= {sda_s_q[1:0], sda_in};
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  assign scl_rise = scl_s_q[1] && !scl_s_q[2];
  assign scl_fall = !scl_s_q[1] && scl_s_q[2];
  assign bus_start = scl_s_q[1] && scl_s_q[2] && !sda_s_q[1] && sda_s_q[2];
  assign bus_stop = scl_s_q[1] && scl_s_q[2] && sda_s_q[1] && !sda_s_q[2];

  switch_route_select_pkg::bus_state_t st_q;
  logic [3:0] cnt_q;
  logic ack_q;
  logic rw_q;
  logic [7:0] shift_q;
  logic [7:0] ptr_q;
  logic [7:0] fast_reg_q;
  logic [7:0] side_reg_q;
  logic wr_en;
  logic [7:0] rd_byte;

  // A data byte is committed only once all eight bits have arrived
  assign wr_en = scl_fall && st_q == switch_route_select_pkg::ST_WR && !ack_q &&
                 cnt_q == `BUS_BITS;
  assign rd_byte = (ptr_q == `REG_FAST_ROUTE) ? fast_reg_q :
                   (ptr_q == `REG_SIDE_ROUTE) ? side_reg_q : 8'h00;

  // Bus protocol sequencing
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= switch_route_select_pkg::ST_IDLE;
      cnt_q <= 4'h0;
      ack_q <= 1'b0;
      rw_q <= 1'b0;
      shift_q <= 8'h00;
      ptr_q <= 8'h00;
      sda_drive_b <= 1'b1;
    end else if (bus_start) begin
      st_q <= switch_route_select_pkg::ST_ADDR;
      cnt_q <= 4'h0;
      ack_q <= 1'b0;
      sda_drive_b <= 1'b1;
    end else if (bus_stop) begin
      st_q <= switch_route_select_pkg::ST_IDLE;
      sda_drive_b <= 1'b1;
    end else if (st_q != switch_route_select_pkg::ST_IDLE) begin
      if (scl_rise && !ack_q && cnt_q != `BUS_BITS) begin
        shift_q <= {shift_q[6:0], sda_s_q[1]};
        cnt_q <= cnt_q + 4'h1;
      end else if (scl_rise && ack_q && st_q == switch_route_select_pkg::ST_RD &&
                   sda_s_q[1]) begin
        // Master declined further data
        st_q <= switch_route_select_pkg::ST_IDLE;
      end else if (scl_fall && !ack_q && cnt_q == `BUS_BITS) begin
        ack_q <= 1'b1;
        unique case (st_q)
          switch_route_select_pkg::ST_ADDR: begin
            if (shift_q[7:1] == DEV_ADDR) begin
              sda_drive_b <= 1'b0;
              rw_q <= shift_q[0];
            end else begin
              st_q <= switch_route_select_pkg::ST_IDLE;
              ack_q <= 1'b0;
            end
          end
          switch_route_select_pkg::ST_PTR: begin
            ptr_q <= shift_q;
            sda_drive_b <= 1'b0;
          end
          switch_route_select_pkg::ST_WR: sda_drive_b <= 1'b0;
          default: sda_drive_b <= 1'b1;
        endcase
      end else if (scl_fall && ack_q) begin
        ack_q <= 1'b0;
        cnt_q <= 4'h0;
        sda_drive_b <= 1'b1;
        unique case (st_q)
          switch_route_select_pkg::ST_ADDR: begin
            if (rw_q) begin
              st_q <= switch_route_select_pkg::ST_RD;
              shift_q <= rd_byte;
              sda_drive_b <= rd_byte[7];
            end else begin
              st_q <= switch_route_select_pkg::ST_PTR;
            end
          end
          switch_route_select_pkg::ST_PTR: st_q <= switch_route_select_pkg::ST_WR;
          switch_route_select_pkg::ST_WR: ptr_q <= ptr_q + 8'h01;
          default: begin
            // Next byte of a burst read
            shift_q <= (ptr_q + 8'h01 == `REG_SIDE_ROUTE) ? side_reg_q : 8'h00;
            sda_drive_b <= (ptr_q + 8'h01 == `REG_SIDE_ROUTE) ? side_reg_q[7] : 1'b1;
            ptr_q <= ptr_q + 8'h01;
          end
        endcase
      end else if (scl_fall && st_q == switch_route_select_pkg::ST_RD) begin
        // Open drain: a one is sent by releasing the line; the byte shifts on every rise
        sda_drive_b <= (cnt_q == `BUS_BITS) ? 1'b1 : shift_q[7];
      end
    end
  end

  // Only a low is ever driven on the data line
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
    end
  end

  // Mode registers
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      fast_reg_q <= `ROUTE_RESET;
      side_reg_q <= `ROUTE_RESET;
    end else if (wr_en && ptr_q == `REG_FAST_ROUTE) begin
      fast_reg_q <= reg_write(fast_reg_q, shift_q);
    end else if (wr_en && ptr_q == `REG_SIDE_ROUTE) begin
      side_reg_q <= reg_write(side_reg_q, shift_q);
    end
  end

  // Crossbar controls follow the committed registers one cycle later
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      fast_route_q <= `ROUTE_RESET_DECODE;
      side_common_lines_q <= `ROUTE_RESET_DECODE;
    end else begin
      fast_route_q <= route_of(fast_reg_q, 1'b0);
      side_common_lines_q <= route_of(side_reg_q, 1'b1);
    end
  end

  property p_fast_on;
    @(posedge core_clk) disable iff (!rst_b)
      ##1 fast_route_q.on == $past(fast_reg_q[`ROUTE_EN_BIT]);
  endproperty
  a_fast_on: assert property (p_fast_on) else $error("fast enable not followed");

  property p_fast_illegal;
    @(posedge core_clk) disable iff (!rst_b)
      wr_en && ptr_q == `REG_FAST_ROUTE && shift_q[5:4] == `MODE_ILLEGAL
      |=> ($stable(fast_reg_q[5:4]) && fast_reg_q[3:0] == $past(shift_q[3:0]))
          ##1 (fast_route_q.on == $past(shift_q[6], 2));
  endproperty
  a_fast_illegal: assert property (p_fast_illegal) else $error("fast illegal mode taken");

  property p_side_illegal;
    @(posedge core_clk) disable iff (!rst_b) side_reg_q[5:4] != `MODE_ILLEGAL;
  endproperty
  a_side_illegal: assert property (p_side_illegal) else $error("side mode holds 11");

  property p_quad;
    @(posedge core_clk) disable iff (!rst_b)
      fast_reg_q[5:4] == `MODE_QUAD && $stable(fast_reg_q)
      |=> fast_route_q.pick[3] == {$past(fast_reg_q[1:0]), 2'h3} &&
          fast_route_q.pick[0] == {$past(fast_reg_q[1:0]), 2'h0};
  endproperty
  a_quad: assert property (p_quad) else $error("quad routing wrong");

  property p_dual;
    @(posedge core_clk) disable iff (!rst_b)
      fast_reg_q[5:4] == `MODE_DUAL && $stable(fast_reg_q)
      |=> fast_route_q.pick[1] == {$past(fast_reg_q[2:0]), 1'b0} &&
          fast_route_q.pick[2] == {$past(fast_reg_q[2:0]), 1'b1};
  endproperty
  a_dual: assert property (p_dual) else $error("dual routing wrong");

  property p_single;
    @(posedge core_clk) disable iff (!rst_b)
      side_reg_q[5:4] == `MODE_SINGLE && $stable(side_reg_q)
      |=> side_common_lines_q.pick[2] == $past(side_reg_q[3:0]);
  endproperty
  a_single: assert property (p_single) else $error("side single routing wrong");

  property p_side_dual;
    @(posedge core_clk) disable iff (!rst_b)
      side_reg_q[5:4] == `MODE_DUAL && $stable(side_reg_q)
      |=> side_common_lines_q.pick[0][3] == 1'b0 && side_common_lines_q.pick[3][3] == 1'b1;
  endproperty
  a_side_dual: assert property (p_side_dual) else $error("side dual routing wrong");

  property p_commit;
    @(posedge core_clk) disable iff (!rst_b)
      $changed(fast_reg_q) |-> $past(wr_en);
  endproperty
  a_commit: assert property (p_commit) else $error("register changed without full byte");

  c_write: cover property (@(posedge core_clk) disable iff (!rst_b) wr_en);
  c_read: cover property (@(posedge core_clk) disable iff (!rst_b)
    st_q == switch_route_select_pkg::ST_RD && scl_fall);
  c_standby: cover property (@(posedge core_clk) disable iff (!rst_b) !fast_route_q.on);
endmodule

/* include/switch_route_select_defines.svh */
// Register offsets, field positions, reset values and mode codes of the route switch
`ifndef SWITCH_ROUTE_SELECT_DEFINES_SVH
`define SWITCH_ROUTE_SELECT_DEFINES_SVH
`define REG_FAST_ROUTE 8'h00
`define REG_SIDE_ROUTE 8'h01
`define ROUTE_RESET 8'h40
// Crossbar controls for the reset value: enabled, quad, source A
`define ROUTE_RESET_DECODE 17'h13210
`define ROUTE_EN_BIT 6
`define ROUTE_MODE_HI 5
`define ROUTE_MODE_LO 4
`define ROUTE_PICK_HI 3
`define MODE_QUAD 2'h0
`define MODE_DUAL 2'h1
`define MODE_SINGLE 2'h2
`define MODE_ILLEGAL 2'h3
`define BUS_BITS 4'h8
`endif

/* include/switch_route_select_pkg.sv */
// Types shared by the route switch control logic
package switch_route_select_pkg;
  // Per output line: 4-bit input index, source in bits 3:2, channel in bits 1:0
  typedef struct packed {
    logic on;
    logic [3:0][3:0] pick;
  } route_t;
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_PTR, ST_WR, ST_RD} bus_state_t;
endpackage

/* sim/route_bus_master.sv */
// Serial bus controller model that writes and reads the route registers
`timescale 1ns/1ps
module route_bus_master #(
  parameter logic [6:0] DEV_ADDR = 7'h48 // Arbitrary bus address
) (
  // Clock
  input wire logic core_clk,
  // Serial bus, open drain data
  output logic scl,
  output logic sda_drive_b,
  input wire logic sda_wire
);
  initial begin
    scl = 1'b1;
    sda_drive_b = 1'b1;
  end
  // Ten clocks per half bit keeps clear of the slave's pin synchronizer lag
  task automatic hp();
    repeat (10) @(posedge core_clk);
    #1;
  endtask
  // Data moves a few clocks after scl falls so it never races the clock edge
  task automatic gap();
    repeat (5) @(posedge core_clk);
    #1;
  endtask
  task automatic start();
    gap();
    sda_drive_b = 1'b1;
    hp();
    scl = 1'b1;
    hp();
    sda_drive_b = 1'b0;
    hp();
    scl = 1'b0;
  endtask
  task automatic stop();
    gap();
    sda_drive_b = 1'b0;
    hp();
    scl = 1'b1;
    hp();
    sda_drive_b = 1'b1;
    hp();
  endtask
  task automatic bit_slot(input logic level, output logic seen);
    gap();
    sda_drive_b = level;
    hp();
    scl = 1'b1;
    hp();
    seen = sda_wire;
    scl = 1'b0;
  endtask
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      bit_slot(tx[i], rx[i]);
    end
  endtask
  task automatic put(input logic [7:0] tx, output logic ack);
    logic [7:0] rx;
    logic s;
    xfer(tx, rx);
    bit_slot(1'b1, s);
    ack = ~s;
  endtask
  task automatic wr_reg(input logic [7:0] ptr, input logic [7:0] data, output logic ack);
    logic a0, a1, a2;
    start();
    put({DEV_ADDR, 1'b0}, a0);
    put(ptr, a1);
    put(data, a2);
    stop();
    ack = a0 & a1 & a2;
  endtask
  // Read ends with a not-acknowledge so the slave lets go of the line
  task automatic rd_reg(input logic [7:0] ptr, output logic [7:0] data);
    logic a, s;
    start();
    put({DEV_ADDR, 1'b0}, a);
    put(ptr, a);
    start();
    put({DEV_ADDR, 1'b1}, a);
    xfer(8'hFF, data);
    bit_slot(1'b1, s);
    stop();
  endtask
endmodule

/* sim/test_switch_route_select.sv */
// Self-checking bench for the route select switch control
`timescale 1ns/1ps
module test_switch_route_select;
  logic core_clk;
  logic rst_b;
  logic scl;
  logic sda_m_b;
  logic sda_out;
  logic sda_drive_b;
  logic sda_wire;
  switch_route_select_pkg::route_t fast_q;
  switch_route_select_pkg::route_t side_q;
  int miscompares = 0;
  int compares = 0;
  int cycles = 0;
  logic [7:0] fast_reg = 8'h40;
  logic [7:0] side_reg = 8'h40;
  // Pulled-up data line, low when either party pulls it
  assign sda_wire = (sda_drive_b | sda_out) & sda_m_b;
  switch_route_select dut (.core_clk(core_clk), .rst_b(rst_b), .scl(scl), .sda_in(sda_wire),
    .sda_out(sda_out), .sda_drive_b(sda_drive_b), .fast_route_q(fast_q),
    .side_common_lines_q(side_q));
  route_bus_master m (.core_clk(core_clk), .scl(scl), .sda_drive_b(sda_m_b),
    .sda_wire(sda_wire));
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic tally_and_finish();
    if (miscompares == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [16:0] seen, input logic [16:0] want);
    compares++;
    if (seen !== want) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
    end
  endtask
  function automatic switch_route_select_pkg::route_t exp_rt(logic [7:0] r, logic side);
    switch_route_select_pkg::route_t e;
    logic [1:0] k;
    e.on = r[6];
    for (int i = 0; i < 4; i++) begin
      k = i[1:0];
      case (r[5:4])
        2'h0: e.pick[i] = {r[1:0], k};
        2'h1: e.pick[i] = side ? {k[1], r[2:0]} : {r[2:0], k[1]};
        default: e.pick[i] = r[3:0];
      endcase
    end
    return e;
  endfunction
  task automatic routes_hold();
    chk(fast_q, exp_rt(fast_reg, 1'b0));
    chk(side_q, exp_rt(side_reg, 1'b1));
  endtask
  // Mode code 11 leaves the held mode but still takes enable and pick
  task automatic apply(input logic [7:0] ptr, input logic [7:0] v);
    logic ack;
    logic [7:0] held;
    logic [7:0] rd;
    held = ptr[0] ? side_reg : fast_reg;
    held = {1'b0, v[6], (v[5:4] == 2'h3) ? held[5:4] : v[5:4], v[3:0]};
    if (ptr[0])
      side_reg = held;
    else
      fast_reg = held;
    m.wr_reg(ptr, v, ack);
    chk({16'h0, ack}, 17'h1);
    routes_hold();
    m.rd_reg(ptr, rd);
    chk({9'h0, rd}, {9'h0, held});
  endtask
  task automatic scen_reset();
    logic [7:0] rd;
    routes_hold();
    m.rd_reg(8'h00, rd);
    chk({9'h0, rd}, 17'h40);
    m.rd_reg(8'h01, rd);
    chk({9'h0, rd}, 17'h40);
  endtask
  task automatic scen_fast();
    apply(8'h00, 8'h4F);
    apply(8'h00, 8'h5F);
    apply(8'h00, 8'h58);
    apply(8'h00, 8'h6B);
    apply(8'h00, 8'h0E);
    apply(8'h00, 8'h7A);
    apply(8'h00, 8'h5F);
    apply(8'h00, 8'h35);
  endtask
  task automatic scen_side();
    apply(8'h01, 8'h4E);
    apply(8'h01, 8'h5A);
    apply(8'h01, 8'h5C);
    apply(8'h01, 8'h66);
    apply(8'h01, 8'h02);
    apply(8'h01, 8'h71);
    apply(8'h01, 8'h51);
    apply(8'h01, 8'h3B);
  endtask
  // Pointer-only write and an unmapped write must leave the routing alone
  task automatic scen_partial();
    logic a;
    logic [7:0] rd;
    m.start();
    m.put({7'h48, 1'b0}, a);
    m.put(8'h00, a);
    m.stop();
    routes_hold();
    m.wr_reg(8'h10, 8'hFF, a);
    routes_hold();
    m.rd_reg(8'h10, rd);
    chk({9'h0, rd}, 17'h0);
  endtask
  initial begin
    rst_b = 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
    rst_b = 1'b1;
    repeat (3) @(posedge core_clk);
    scen_reset();
    scen_fast();
    scen_side();
    scen_partial();
    tally_and_finish();
  end
endmodule
